// [design/mbsr_map.vh]
`ifndef MBSR_MAP_VH
`define MBSR_MAP_VH
// Register word addresses (holding register numbers).
`define MBSR_A_SP_SRC 16'h022d
`define MBSR_A_MOD_SNS 16'h022e
`define MBSR_A_BKP_SNS 16'h022f
`define MBSR_A_LO_TEMP 16'h0230
`define MBSR_A_HI_TEMP 16'h0231
`define MBSR_A_BUS_SP 16'h0232
`define MBSR_A_SEQ_CALL 16'h0233
`define MBSR_A_RUN_MODE 16'h0234
`define MBSR_A_CMD 16'h0235
`define MBSR_A_BASE_RATE 16'h0236
`define MBSR_A_FAN_RATE 16'h0237
`define MBSR_A_SEQ_ORDER 16'h0238
`define MBSR_A_PORT 16'h0239
`define MBSR_A_FIRE_DLY 16'h023a
`define MBSR_A_CAPACITY 16'h023b
`define MBSR_A_COMMON_RATE 16'h023c
`define MBSR_A_RATE_ALLOC 16'h023d
`define MBSR_A_LEAD_ALLOC 16'h023e
`define MBSR_A_LAG_ALLOC 16'h023f
`define MBSR_A_CH_CALL 16'h0241
// Reset values.
`define MBSR_RST_ZERO 16'h0000
`define MBSR_RST_NOT_CFG 16'hffff
`define MBSR_NOT_CFG 16'hffff
// Field encodings.
`define MBSR_SP_LOCAL 2'h0
`define MBSR_SP_BUS 2'h1
`define MBSR_SP_ANALOG 2'h2
`define MBSR_SNS_FIFTH 1'h0
`define MBSR_SNS_TENTH 1'h1
`define MBSR_BKP_NONE 2'h0
`define MBSR_BKP_LEAD 2'h1
`define MBSR_BKP_AVG 2'h2
`define MBSR_MODE_FIRST 2'h0
`define MBSR_MODE_EQUAL 2'h1
`define MBSR_MODE_LAST 2'h2
`define MBSR_PORT_NONE 2'h0
`define MBSR_PORT_LOCAL 2'h1
`define MBSR_PORT_GLOBAL 2'h2
// Command word bit positions.
`define MBSR_CMD_DEMAND 15
`define MBSR_CMD_SUSPEND 14
`define MBSR_CMD_FAN 13
`define MBSR_CMD_PUMP_X 12
`define MBSR_CMD_PUMP_Y 11
`define MBSR_CMD_PUMP_Z 10
`define MBSR_CMD_RSVD 9
`define MBSR_CMD_FRACTION 8
`define MBSR_CMD_RATE_HI 7
`define MBSR_CMD_RATE_LO 0
// Limits.
`define MBSR_TEMP_MIN 16'hfe70
`define MBSR_TEMP_MAX 16'h0514
`define MBSR_DELAY_MAX 16'hfd20
`define MBSR_RATE_MAX 16'h03e8
`define MBSR_CODE_MAX 16'h0002
`define MBSR_FLAG_MAX 16'h0001
`define MBSR_ORDER_MAX 16'h00ff
// Selector and flag field positions in a stored word.
`define MBSR_SEL_HI 1
`define MBSR_SEL_LO 0
`define MBSR_FLAG_BIT 0
`endif

// [design/mbsr_word.v]
`timescale 1ns/1ns
// One holding register with an optional write filter applied by the parent.
module mbsr_word #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   input wire clock,
   input wire rst_n,
   input wire clkEn,
   input wire wrEn,
   input wire [WIDTH-1:0] wrData,
   output reg [WIDTH-1:0] value_q
);
   always @(posedge clock) begin
      if (!rst_n) begin
         value_q <= RESET_VALUE;
      end else if (clkEn && wrEn) begin
         value_q <= wrData;
      end
   end
endmodule // mbsr_word

// [design/mbsr_regs.v]
`timescale 1ns/1ns
`include "mbsr_map.vh"
//
// How it works
// RULE1: setpoint source 0 local, 1 bus, 2 analog.
// RULE2: modulation sensor 0 fifth, 1 tenth input.
// RULE3: backup 0 none, 1 lead, 2 average.
// RULE4: loop temperatures -40..130 C, tenth degrees.
// RULE5: call-for-heat words: 0 idle, 1 demand.
// RULE6: slave mode first, equalize, or last.
// RULE7: command bits 15..13 demand, suspend, fan.
// RULE8: command bits 12..10 drive pumps X, Y, Z.
// RULE9: bit 9 zero, bit 8 fraction, rate 7..0.
// RULE10: port word 0 none, 1 local, 2 global.
// RULE11: fire delay 0..64800 s or 0xFFFF.
// RULE12: common rate 0 disabled, else tenth-percent.
// RULE13: rate allocation supports only value 0.
// RULE14: lead/lag allocation rotation or lowest runtime.
// RULE15: capacity word in kilo BTU per hour.
// RULE16: every word is read/write 16-bit; temperature words are signed.
//
// The protocol engine presents one word access per strobe. Writes that fall
// outside a word's legal set are refused: the word keeps its value and
// wrRefused pulses. Reads answer one cycle later with rdValid; an address
// outside the bank gives zero data and rdUnmapped.
module mbsr_regs (
   input wire clock,
   input wire rst_n,
   input wire clkEn,
   input wire wrStrobe,
   input wire rdStrobe,
   input wire [15:0] wordAddr,
   input wire [15:0] wrData,
   output reg [15:0] rdData_q,
   output reg rdValid_q,
   output reg rdUnmapped_q,
   output reg wrAck_q,
   output reg wrRefused_q,
   output reg [1:0] setpointSel_q,
   output reg modSensorSel_q,
   output reg [1:0] backupSensorSel_q,
   output reg [1:0] slaveMode_q,
   output reg [1:0] busPortSel_q,
   output reg seqHeatDemand_q,
   output reg centralHeatingDemand_q,
   output reg slaveDemand_q,
   output reg suspendStartup_q,
   output reg fanRequest_q,
   output reg pumpX_q,
   output reg pumpY_q,
   output reg pumpZ_q,
   output reg rateIsFraction_q,
   output reg [7:0] commandedRate_q,
   output reg baseLoadEnabled_q,
   output reg leadLowestRuntime_q,
   output reg lagLowestRuntime_q,
   output reg fireDelayConfigured_q
);

   ////////////////////////////////////////////////////////////////////////////
   localparam NWORDS = 20;

   wire [15:0] wordVal [0:NWORDS-1];
   reg [NWORDS-1:0] hit;
   reg legal;

   always @* begin
      hit = {NWORDS{1'b0}};
      case (wordAddr)
         `MBSR_A_SP_SRC: hit[0] = 1'b1;
         `MBSR_A_MOD_SNS: hit[1] = 1'b1;
         `MBSR_A_BKP_SNS: hit[2] = 1'b1;
         `MBSR_A_LO_TEMP: hit[3] = 1'b1;
         `MBSR_A_HI_TEMP: hit[4] = 1'b1;
         `MBSR_A_BUS_SP: hit[5] = 1'b1;
         `MBSR_A_SEQ_CALL: hit[6] = 1'b1;
         `MBSR_A_RUN_MODE: hit[7] = 1'b1;
         `MBSR_A_CMD: hit[8] = 1'b1;
         `MBSR_A_BASE_RATE: hit[9] = 1'b1;
         `MBSR_A_FAN_RATE: hit[10] = 1'b1;
         `MBSR_A_SEQ_ORDER: hit[11] = 1'b1;
         `MBSR_A_PORT: hit[12] = 1'b1;
         `MBSR_A_FIRE_DLY: hit[13] = 1'b1;
         `MBSR_A_CAPACITY: hit[14] = 1'b1;
         `MBSR_A_COMMON_RATE: hit[15] = 1'b1;
         `MBSR_A_RATE_ALLOC: hit[16] = 1'b1;
         `MBSR_A_LEAD_ALLOC: hit[17] = 1'b1;
         `MBSR_A_LAG_ALLOC: hit[18] = 1'b1;
         `MBSR_A_CH_CALL: hit[19] = 1'b1;
         default: hit = {NWORDS{1'b0}};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Legal value check for the addressed word.
   wire signed [15:0] sData = wrData;
   wire tempOk = (sData >= $signed(`MBSR_TEMP_MIN)) && (sData <= $signed(`MBSR_TEMP_MAX));
   wire codeOk = (wrData <= `MBSR_CODE_MAX);
   wire flagOk = (wrData <= `MBSR_FLAG_MAX);
   wire orderOk = (wrData <= `MBSR_ORDER_MAX);
   wire delayOk = (wrData <= `MBSR_DELAY_MAX) || (wrData == `MBSR_NOT_CFG);
   wire rateOk = (wrData <= `MBSR_RATE_MAX);
   wire zeroOk = (wrData == `MBSR_RST_ZERO);

   always @* begin
      legal = 1'b1;
      case (1'b1)
         hit[0]: legal = codeOk; // [RULE1]
         hit[1]: legal = flagOk; // [RULE2]
         hit[2]: legal = codeOk; // [RULE3]
         hit[3]: legal = tempOk; // [RULE4]
         hit[4]: legal = tempOk; // [RULE4]
         hit[5]: legal = tempOk;
         hit[6]: legal = flagOk; // [RULE5]
         hit[7]: legal = codeOk; // [RULE6]
         hit[11]: legal = orderOk;
         hit[12]: legal = codeOk; // [RULE10]
         hit[13]: legal = delayOk; // [RULE11]
         hit[15]: legal = rateOk; // [RULE12]
         hit[16]: legal = zeroOk; // [RULE13]
         hit[17]: legal = flagOk; // [RULE14]
         hit[18]: legal = flagOk; // [RULE14]
         hit[19]: legal = flagOk; // [RULE5]
         default: legal = 1'b1;
      endcase
   end

   wire doWrite = wrStrobe && (|hit) && legal;
   // Reserved command bit is forced to zero on store.
   wire [15:0] storeData = hit[8] ? (wrData & ~(16'h0001 << `MBSR_CMD_RSVD)) : wrData; // [RULE9]

   ////////////////////////////////////////////////////////////////////////////
   // Every word stores 16 bits (command bit 9 cleared); temperature and bus setpoint words are signed. [RULE16]
   wire [NWORDS-1:0] wrEn = hit & {NWORDS{doWrite}};

   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uSpSrc (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[0]), .wrData(storeData), .value_q(wordVal[0])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uModSns (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[1]), .wrData(storeData), .value_q(wordVal[1])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uBkpSns (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[2]), .wrData(storeData), .value_q(wordVal[2])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uLoTemp (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[3]), .wrData(storeData), .value_q(wordVal[3])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uHiTemp (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[4]), .wrData(storeData), .value_q(wordVal[4])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uBusSp (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[5]), .wrData(storeData), .value_q(wordVal[5])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uSeqCall (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[6]), .wrData(storeData), .value_q(wordVal[6])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uRunMode (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[7]), .wrData(storeData), .value_q(wordVal[7])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uCmd (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[8]), .wrData(storeData), .value_q(wordVal[8])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uBaseRate (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[9]), .wrData(storeData), .value_q(wordVal[9])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uFanRate (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[10]), .wrData(storeData), .value_q(wordVal[10])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uSeqOrder (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[11]), .wrData(storeData), .value_q(wordVal[11])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uPort (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[12]), .wrData(storeData), .value_q(wordVal[12])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_NOT_CFG)
   ) uFireDly (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[13]), .wrData(storeData), .value_q(wordVal[13])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uCapacity (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[14]), .wrData(storeData), .value_q(wordVal[14])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uCommonRate (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[15]), .wrData(storeData), .value_q(wordVal[15])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uRateAlloc (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[16]), .wrData(storeData), .value_q(wordVal[16])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uLeadAlloc (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[17]), .wrData(storeData), .value_q(wordVal[17])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uLagAlloc (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[18]), .wrData(storeData), .value_q(wordVal[18])
   );
   mbsr_word #(
      .WIDTH(16), .RESET_VALUE(`MBSR_RST_ZERO)
   ) uChCall (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn),
      .wrEn(wrEn[19]), .wrData(storeData), .value_q(wordVal[19])
   );

   // Read multiplexer: one stored word per mapped address, zero elsewhere.
   reg [15:0] rdMux;
   always @* begin
      case (wordAddr)
         `MBSR_A_SP_SRC: rdMux = wordVal[0];
         `MBSR_A_MOD_SNS: rdMux = wordVal[1];
         `MBSR_A_BKP_SNS: rdMux = wordVal[2];
         `MBSR_A_LO_TEMP: rdMux = wordVal[3];
         `MBSR_A_HI_TEMP: rdMux = wordVal[4];
         `MBSR_A_BUS_SP: rdMux = wordVal[5];
         `MBSR_A_SEQ_CALL: rdMux = wordVal[6];
         `MBSR_A_RUN_MODE: rdMux = wordVal[7];
         `MBSR_A_CMD: rdMux = wordVal[8];
         `MBSR_A_BASE_RATE: rdMux = wordVal[9];
         `MBSR_A_FAN_RATE: rdMux = wordVal[10];
         `MBSR_A_SEQ_ORDER: rdMux = wordVal[11];
         `MBSR_A_PORT: rdMux = wordVal[12];
         `MBSR_A_FIRE_DLY: rdMux = wordVal[13];
         `MBSR_A_CAPACITY: rdMux = wordVal[14]; // [RULE15]
         `MBSR_A_COMMON_RATE: rdMux = wordVal[15];
         `MBSR_A_RATE_ALLOC: rdMux = wordVal[16];
         `MBSR_A_LEAD_ALLOC: rdMux = wordVal[17];
         `MBSR_A_LAG_ALLOC: rdMux = wordVal[18];
         `MBSR_A_CH_CALL: rdMux = wordVal[19];
         default: rdMux = `MBSR_RST_ZERO; // [RULE16]
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer.
   always @(posedge clock) begin
      if (!rst_n) begin
         rdData_q <= `MBSR_RST_ZERO;
         rdValid_q <= 1'b0;
         rdUnmapped_q <= 1'b0;
         wrAck_q <= 1'b0;
         wrRefused_q <= 1'b0;
      end else if (clkEn) begin
         rdValid_q <= rdStrobe;
         rdUnmapped_q <= rdStrobe && !(|hit);
         rdData_q <= rdStrobe ? rdMux : `MBSR_RST_ZERO;
         wrAck_q <= doWrite;
         wrRefused_q <= wrStrobe && !doWrite;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded controls, registered from the stored words.
   always @(posedge clock) begin
      if (!rst_n) begin
         setpointSel_q <= `MBSR_SP_LOCAL;
         modSensorSel_q <= `MBSR_SNS_FIFTH;
         backupSensorSel_q <= `MBSR_BKP_NONE;
         slaveMode_q <= `MBSR_MODE_FIRST;
         busPortSel_q <= `MBSR_PORT_NONE;
         seqHeatDemand_q <= 1'b0;
         centralHeatingDemand_q <= 1'b0;
         slaveDemand_q <= 1'b0;
         suspendStartup_q <= 1'b0;
         fanRequest_q <= 1'b0;
         pumpX_q <= 1'b0;
         pumpY_q <= 1'b0;
         pumpZ_q <= 1'b0;
         rateIsFraction_q <= 1'b0;
         commandedRate_q <= 8'h00;
         baseLoadEnabled_q <= 1'b0;
         leadLowestRuntime_q <= 1'b0;
         lagLowestRuntime_q <= 1'b0;
         fireDelayConfigured_q <= 1'b0;
      end else if (clkEn) begin
         setpointSel_q <= wordVal[0][`MBSR_SEL_HI:`MBSR_SEL_LO]; // [RULE1]
         modSensorSel_q <= wordVal[1][`MBSR_FLAG_BIT]; // [RULE2]
         backupSensorSel_q <= wordVal[2][`MBSR_SEL_HI:`MBSR_SEL_LO]; // [RULE3]
         seqHeatDemand_q <= wordVal[6][`MBSR_FLAG_BIT]; // [RULE5]
         centralHeatingDemand_q <= wordVal[19][`MBSR_FLAG_BIT]; // [RULE5]
         slaveMode_q <= wordVal[7][`MBSR_SEL_HI:`MBSR_SEL_LO]; // [RULE6]
         slaveDemand_q <= wordVal[8][`MBSR_CMD_DEMAND]; // [RULE7]
         suspendStartup_q <= wordVal[8][`MBSR_CMD_SUSPEND]; // [RULE7]
         fanRequest_q <= wordVal[8][`MBSR_CMD_FAN]; // [RULE7]
         pumpX_q <= wordVal[8][`MBSR_CMD_PUMP_X]; // [RULE8]
         pumpY_q <= wordVal[8][`MBSR_CMD_PUMP_Y]; // [RULE8]
         pumpZ_q <= wordVal[8][`MBSR_CMD_PUMP_Z]; // [RULE8]
         rateIsFraction_q <= wordVal[8][`MBSR_CMD_FRACTION]; // [RULE9]
         commandedRate_q <= wordVal[8][`MBSR_CMD_RATE_HI:`MBSR_CMD_RATE_LO]; // [RULE9]
         busPortSel_q <= wordVal[12][`MBSR_SEL_HI:`MBSR_SEL_LO]; // [RULE10]
         fireDelayConfigured_q <= (wordVal[13] != `MBSR_NOT_CFG); // [RULE11]
         baseLoadEnabled_q <= (wordVal[15] != `MBSR_RST_ZERO); // [RULE12]
         leadLowestRuntime_q <= wordVal[17][`MBSR_FLAG_BIT]; // [RULE14]
         lagLowestRuntime_q <= wordVal[18][`MBSR_FLAG_BIT]; // [RULE14]
      end
   end
endmodule // mbsr_regs

// [dv/mbsr_regs_assertions.sv]
`timescale 1ns/1ns
module mbsr_regs_checker (
   input wire clock,
   input wire rst_n,
   input wire clkEn,
   input wire wrStrobe,
   input wire rdStrobe,
   input wire [15:0] wordAddr,
   input wire [15:0] wrData,
   input wire [15:0] rdData_q,
   input wire rdValid_q,
   input wire rdUnmapped_q,
   input wire wrAck_q,
   input wire wrRefused_q,
   input wire fanRequest_q,
   input wire pumpZ_q,
   input wire fireDelayConfigured_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_take(a, c); clkEn && wrStrobe && wordAddr == a && c ##1 clkEn; endsequence
   property p_wrAns; clkEn && wrStrobe |=> wrAck_q != wrRefused_q; endproperty
   a_wrAns: assert property (p_wrAns) else $error("bad write answer");
   property p_rdAns; clkEn && rdStrobe |=> rdValid_q; endproperty
   a_rdAns: assert property (p_rdAns) else $error("read not answered");
   property p_unmap; clkEn && rdStrobe && wordAddr == 16'h0240 |=> rdUnmapped_q && rdData_q == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
   property p_rsvd; clkEn && rdStrobe && wordAddr == 16'h0235 |=> rdData_q[9] == 1'b0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_modRef; clkEn && wrStrobe && wordAddr == 16'h022e && wrData > 16'h0001 |=> wrRefused_q; endproperty
   a_modRef: assert property (p_modRef) else $error("sensor code kept");
   property p_rateRef; clkEn && wrStrobe && wordAddr == 16'h023d && wrData != 16'h0000 |=> wrRefused_q; endproperty
   a_rateRef: assert property (p_rateRef) else $error("allocation code kept");
   property p_cmd;
      s_take(16'h0235, 1'b1) |=> fanRequest_q == $past(wrData[13], 2) && pumpZ_q == $past(wrData[10], 2);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command bits wrong");
   property p_dly; s_take(16'h023a, wrData == 16'hffff) |=> !fireDelayConfigured_q; endproperty
   a_dly: assert property (p_dly) else $error("delay flag wrong");
   property p_freeze;
      !clkEn |=> $stable(rdData_q) && $stable(rdValid_q) && $stable(wrAck_q) && $stable(wrRefused_q)
         && $stable(fanRequest_q) && $stable(fireDelayConfigured_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule // mbsr_regs_checker
bind mbsr_regs mbsr_regs_checker chk (.clock, .rst_n, .clkEn, .wrStrobe, .rdStrobe, .wordAddr, .wrData, .rdData_q,
   .rdValid_q, .rdUnmapped_q, .wrAck_q, .wrRefused_q, .fanRequest_q, .pumpZ_q, .fireDelayConfigured_q);

// [dv/mbsr_bus_master.sv]
`timescale 1ns/1ns
module mbsr_bus_master (
   input wire clock,
   output logic wrStrobe,
   output logic rdStrobe,
   output logic [15:0] wordAddr,
   output logic [15:0] wrData,
   input wire [15:0] rdData_q,
   input wire rdValid_q,
   input wire rdUnmapped_q,
   input wire wrAck_q,
   input wire wrRefused_q
);
   initial begin
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      wordAddr = 16'h0000;
      wrData = 16'h0000;
   end
   // One word per strobe; released lines show the inverse so stale values never pass.
   task automatic access(input bit wr, input logic [15:0] a, d, output logic [15:0] q, output logic [1:0] st);
      @(posedge clock);
      wrStrobe <= wr;
      rdStrobe <= !wr;
      wordAddr <= a;
      wrData <= d;
      @(posedge clock);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      wordAddr <= ~a;
      wrData <= ~d;
      @(negedge clock);
      q = rdData_q;
      st = wr ? {wrAck_q, wrRefused_q} : {rdValid_q, rdUnmapped_q};
   endtask
endmodule // mbsr_bus_master

// [dv/test_mbsr_regs.sv]
`timescale 1ns/1ns
module test_mbsr_regs;
   localparam logic [15:0] ADDR [20] = '{16'h022d, 16'h022e, 16'h022f, 16'h0230, 16'h0231, 16'h0232, 16'h0233,
      16'h0234, 16'h0235, 16'h0236, 16'h0237, 16'h0238, 16'h0239, 16'h023a, 16'h023b, 16'h023c, 16'h023d,
      16'h023e, 16'h023f, 16'h0241};
   localparam logic [15:0] VAL [20] = '{16'h0002, 16'h0001, 16'h0002, 16'hfe70, 16'h0514, 16'hfff6, 16'h0001,
      16'h0002, 16'hffab, 16'habcd, 16'h1234, 16'h00ff, 16'h0002, 16'hfd20, 16'h5a5a, 16'h03e8, 16'h0000,
      16'h0001, 16'h0001, 16'h0001};
   localparam int BADI [8] = '{0, 1, 3, 4, 11, 13, 15, 16};
   localparam logic [15:0] BADV [8] = '{16'h0003, 16'h0002, 16'h0515, 16'hfe6f, 16'h0100, 16'hfd21, 16'h03e9,
      16'h0001};
   localparam int CODE [9] = '{0, 2, 7, 12, 1, 6, 19, 17, 18};
   logic clock, rst_n, clkEn;
   logic [15:0] q;
   logic [1:0] st;
   int failures, checks_done;
   wire wrStrobe, rdStrobe, rdValid_q, rdUnmapped_q, wrAck_q, wrRefused_q, modSensorSel_q, seqHeatDemand_q;
   wire centralHeatingDemand_q, slaveDemand_q, suspendStartup_q, fanRequest_q, pumpX_q, pumpY_q, pumpZ_q;
   wire rateIsFraction_q, baseLoadEnabled_q, leadLowestRuntime_q, lagLowestRuntime_q, fireDelayConfigured_q;
   wire [15:0] wordAddr, wrData, rdData_q;
   wire [1:0] setpointSel_q, backupSensorSel_q, slaveMode_q, busPortSel_q;
   wire [7:0] commandedRate_q;
   wire [29:0] decoded = {setpointSel_q, modSensorSel_q, backupSensorSel_q, slaveMode_q, busPortSel_q,
      seqHeatDemand_q, centralHeatingDemand_q, slaveDemand_q, suspendStartup_q, fanRequest_q, pumpX_q, pumpY_q,
      pumpZ_q, rateIsFraction_q, commandedRate_q, baseLoadEnabled_q, leadLowestRuntime_q, lagLowestRuntime_q,
      fireDelayConfigured_q};
   wire [7:0] codes = {setpointSel_q, backupSensorSel_q, slaveMode_q, busPortSel_q};
   wire [4:0] flags = {modSensorSel_q, seqHeatDemand_q, centralHeatingDemand_q, leadLowestRuntime_q,
      lagLowestRuntime_q};
   mbsr_regs dut (.clock, .rst_n, .clkEn, .wrStrobe, .rdStrobe, .wordAddr, .wrData, .rdData_q, .rdValid_q,
      .rdUnmapped_q, .wrAck_q, .wrRefused_q, .setpointSel_q, .modSensorSel_q, .backupSensorSel_q, .slaveMode_q,
      .busPortSel_q, .seqHeatDemand_q, .centralHeatingDemand_q, .slaveDemand_q, .suspendStartup_q, .fanRequest_q,
      .pumpX_q, .pumpY_q, .pumpZ_q, .rateIsFraction_q, .commandedRate_q, .baseLoadEnabled_q, .leadLowestRuntime_q,
      .lagLowestRuntime_q, .fireDelayConfigured_q);
   mbsr_bus_master m (.clock, .wrStrobe, .rdStrobe, .wordAddr, .wrData, .rdData_q, .rdValid_q, .rdUnmapped_q,
      .wrAck_q, .wrRefused_q);
   always #50 clock = ~clock;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, d, input logic [1:0] e);
      m.access(1'b1, a, d, q, st);
      chk("write status", st, e);
   endtask
   task automatic rd(input logic [15:0] a, e);
      m.access(1'b0, a, 16'h0000, q, st);
      chk("read status", st, a == 16'h0240 ? 2'b11 : 2'b10);
      chk("read data", q, e);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 20; i++) rd(ADDR[i], ADDR[i] == 16'h023a ? 16'hffff : 16'h0000);
      chk("decoded", decoded, 30'h0000_0000);
   endtask
   task automatic t_store_all;
      for (int i = 0; i < 20; i++) wr(ADDR[i], VAL[i], 2'b10);
      for (int i = 0; i < 20; i++) rd(ADDR[i], ADDR[i] == 16'h0235 ? VAL[i] & 16'hfdff : VAL[i]);
      chk("decoded", decoded, {2'h2, 1'b1, 6'h2a, 2'h3, 6'h3f, 1'b1, 8'hab, 4'hf});
   endtask
   task automatic t_refuse;
      for (int i = 0; i < 8; i++) begin
         wr(ADDR[BADI[i]], BADV[i], 2'b01);
         rd(ADDR[BADI[i]], VAL[BADI[i]]);
      end
      wr(16'h0240, 16'h0001, 2'b01);
      rd(16'h0240, 16'h0000);
   endtask
   task automatic t_codes;
      for (int k = 0; k < 3; k++) begin
         for (int j = 0; j < 9; j++) if (j < 4 || k < 2) wr(ADDR[CODE[j]], 16'(k), 2'b10);
         @(negedge clock);
         chk("codes", codes, {4{2'(k)}});
         chk("flags", flags, {5{k != 0}});
      end
      wr(16'h023a, 16'hffff, 2'b10);
      @(negedge clock);
      chk("delay flag", fireDelayConfigured_q, 1'b0);
   endtask
   task automatic t_freeze;
      wr(16'h0233, 16'h0001, 2'b10);
      @(posedge clock) clkEn <= 1'b0;
      m.access(1'b1, 16'h0233, 16'h0000, q, st);
      chk("frozen status", st, 2'b00);
      @(posedge clock) clkEn <= 1'b1;
      rd(16'h0233, 16'h0001);
      chk("frozen demand", seqHeatDemand_q, 1'b1);
   endtask
   task automatic t_midreset;
      @(posedge clock);
      rst_n <= 1'b0;
      clkEn <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      clkEn <= 1'b1;
      t_reset();
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #500000;
      failures++;
      stop_test();
   end
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      clkEn = 1'b1;
      failures = 0;
      checks_done = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_store_all();
      t_refuse();
      t_codes();
      t_freeze();
      t_midreset();
      stop_test();
   end
endmodule // test_mbsr_regs
